// ### hw/mdc_crc.sv
`timescale 1ns/1ps
`default_nettype none

package mdc_pkg;
    localparam logic [7:0] FN_DIAG = 8'h08;
    localparam logic [7:0] EXC_MARK = 8'h80;
    localparam logic [7:0] EXC_NONE = 8'h00;
    localparam logic [7:0] EXC_ILL_FUNC = 8'h01;
    localparam logic [7:0] EXC_ILL_ADDR = 8'h02;
    localparam logic [7:0] EXC_ILL_VALUE = 8'h03;
    localparam logic [7:0] EXC_DEV_FAIL = 8'h04;
    localparam logic [15:0] SUB_BUSY_CNT = 16'h0011;
    localparam logic [15:0] SUB_OVR_CNT = 16'h0012;
    localparam logic [15:0] SUB_OVR_CLR = 16'h0014;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [15:0] BUSY_COUNT = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'hA001;
    localparam logic [15:0] CRC_RESIDUE = 16'h0000;
    localparam logic [3:0] REQ_LEN = 4'h8;
    localparam logic [3:0] REQ_MIN = 4'h4;
    localparam logic [3:0] RX_CNT_MAX = 4'hF;
    localparam logic [3:0] LEN_NORMAL = 4'h6;
    localparam logic [3:0] LEN_EXC = 4'h3;
    localparam logic [3:0] CNT_STEP = 4'h1;
    localparam logic [3:0] IDX_ZERO = 4'h0;
    localparam logic [3:0] IDX_CRC_HI = 4'h1;
    localparam logic [3:0] IDX_DONE = 4'h2;
    localparam int BUF_DEPTH = 8;
    localparam int IDX_ADDR = 0;
    localparam int IDX_FN = 1;
    localparam int IDX_SUB_HI = 2;
    localparam int IDX_SUB_LO = 3;
    localparam int IDX_DAT_HI = 4;
    localparam int IDX_DAT_LO = 5;

    typedef struct packed {
        logic valid;
        logic eof;
        logic [7:0] data;
    } mdc_rx_t;

    typedef struct packed {
        logic valid;
        logic last;
        logic [7:0] data;
    } mdc_tx_t;

    typedef enum logic [2:0] {
        ST_RX = 3'b000,
        ST_EVAL = 3'b001,
        ST_TX = 3'b010
    } mdc_state_t;
endpackage

module mdc_crc
    import mdc_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic init,
    input wire logic upd,
    input wire logic [7:0] data,
    output logic [15:0] crc
);
    logic [15:0] crc_reg;
    logic [15:0] crc_next;

    // One whole byte per cycle, LSB first, reflected form
    always_comb begin
        crc_next = crc_reg ^ {8'h00, data};
        for (int i = 0; i < 8; i++) begin
            crc_next = crc_next[0] ? ((crc_next >> 1) ^ CRC_POLY) : (crc_next >> 1);
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            crc_reg <= CRC_INIT;
        end else if (ce) begin
            if (init) begin
                crc_reg <= CRC_INIT;
            end else if (upd) begin
                crc_reg <= crc_next;
            end
        end
    end

    assign crc = crc_reg;
endmodule // mdc_crc

`default_nettype wire

// ### hw/mdc_responder.sv
// Function
// - Sub-function 0011 with zero data is echoed with a busy count that is always zero.
// - Every counter clears at reset, on unit restart and on a clear-all-counters command.
// - Counters stop at FFFF and resume only after being cleared.
// - The overrun counter adds one for each received character that overwrote unread data.
// - Sub-function 0012 with zero data is echoed with the overrun count, high byte first.
// - The overrun counter also clears whenever the overrun clear command executes.
// - Sub-function 0014 zeroes the overrun counter and drops the overrun flag.
// - After the overrun clear the reply repeats the request with a fresh CRC.
// - Frames are address, function, sub-function hi/lo, data hi/lo, CRC lo then hi.
// - A failed diagnostics request gets function 88 and one exception code byte.
// - An unimplemented function code gets exception 01.
// - A request aimed at an address without data gets exception 02.
// - A request value outside its allowed range gets exception 03.
// - A request of the wrong length gets exception 04 and the master resends; a bad CRC or a foreign address gets no reply.
// - The overrun count sits in the two data bytes as 0000 to FFFF, upper byte first.
`timescale 1ns/1ps
`default_nettype none

module mdc_responder
    import mdc_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic [7:0] own_addr,
    input wire mdc_rx_t rx,
    input wire logic tx_ready,
    input wire logic overrun_evt,
    input wire logic restart,
    input wire logic diag_clear,
    output mdc_tx_t tx,
    output logic overrun_flag,
    output logic [15:0] overrun_count,
    output logic busy
);
    function automatic logic [15:0] word_of(input logic [7:0] hi, input logic [7:0] lo);
        word_of = {hi, lo};
    endfunction

    logic [7:0] req_reg [BUF_DEPTH];
    logic [7:0] resp_reg [BUF_DEPTH];
    logic [3:0] rx_cnt_reg;
    logic [3:0] resp_len_reg;
    logic [3:0] idx_reg;
    mdc_state_t state_reg;
    mdc_tx_t tx_reg;
    logic [15:0] ovr_cnt_reg;
    logic [15:0] ovr_cnt_next;
    logic ovr_flag_reg;
    logic busy_reg;
    logic [15:0] crc;

    wire logic in_rx = (state_reg == ST_RX);
    wire logic in_eval = (state_reg == ST_EVAL);
    wire logic in_tx = (state_reg == ST_TX);
    wire logic rx_take = in_rx && rx.valid;
    wire logic [7:0] req_fn = req_reg[IDX_FN];
    wire logic [15:0] req_sub = word_of(req_reg[IDX_SUB_HI], req_reg[IDX_SUB_LO]);
    wire logic [15:0] req_data = word_of(req_reg[IDX_DAT_HI], req_reg[IDX_DAT_LO]);
    // Residue of zero over the whole frame means the trailing CRC matched
    wire logic frame_ok = (req_reg[IDX_ADDR] == own_addr) && (crc == CRC_RESIDUE)
        && (rx_cnt_reg >= REQ_MIN);
    wire logic sub_known = (req_sub == SUB_BUSY_CNT) || (req_sub == SUB_OVR_CNT)
        || (req_sub == SUB_OVR_CLR);
    wire logic [7:0] exc_code =
        (req_fn != FN_DIAG) ? EXC_ILL_FUNC :
        (rx_cnt_reg != REQ_LEN) ? EXC_DEV_FAIL :
        !sub_known ? EXC_ILL_ADDR :
        (req_data != WORD_ZERO) ? EXC_ILL_VALUE :
        EXC_NONE;
    wire logic is_exc = (exc_code != EXC_NONE);
    wire logic ovr_clr_cmd = in_eval && frame_ok && !is_exc && (req_sub == SUB_OVR_CLR);
    wire logic [15:0] reply_word = (req_sub == SUB_OVR_CNT) ? ovr_cnt_reg :
        (req_sub == SUB_BUSY_CNT) ? BUSY_COUNT : req_data;
    wire logic clr_all = restart || diag_clear || ovr_clr_cmd;
    wire logic ovr_at_max = (ovr_cnt_reg == CNT_MAX);
    wire logic slot_free = !tx_reg.valid || tx_ready;
    wire logic [3:0] idx_crc_lo = resp_len_reg;
    wire logic [3:0] idx_crc_hi = resp_len_reg + IDX_CRC_HI;
    wire logic [3:0] idx_end = resp_len_reg + IDX_DONE;
    wire logic tx_load = in_tx && slot_free && (idx_reg != idx_end);
    wire logic tx_body = tx_load && (idx_reg < idx_crc_lo);
    wire logic tx_finish = in_tx && slot_free && (idx_reg == idx_end);
    wire logic crc_init = (in_eval) || tx_finish || (in_rx && rx.eof && !rx.valid
        && (rx_cnt_reg == IDX_ZERO));
    wire logic crc_upd = rx_take || tx_body;
    wire logic [7:0] crc_data = in_tx ? resp_reg[idx_reg[2:0]] : rx.data;
    wire logic [7:0] tx_byte = (idx_reg == idx_crc_lo) ? crc[7:0] :
        (idx_reg == idx_crc_hi) ? crc[15:8] : resp_reg[idx_reg[2:0]];

    // A simultaneous event beats any clear, so no overrun is lost
    assign ovr_cnt_next = overrun_evt ? (clr_all ? CNT_ONE :
        (ovr_at_max ? ovr_cnt_reg : ovr_cnt_reg + CNT_ONE)) :
        (clr_all ? WORD_ZERO : ovr_cnt_reg);

    mdc_crc u_crc (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .init(crc_init),
        .upd(crc_upd),
        .data(crc_data),
        .crc(crc)
    );

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ovr_cnt_reg <= WORD_ZERO;
            ovr_flag_reg <= 1'b0;
        end else if (ce) begin
            ovr_cnt_reg <= ovr_cnt_next;
            if (overrun_evt) begin
                ovr_flag_reg <= 1'b1;
            end else if (ovr_clr_cmd || restart) begin
                ovr_flag_reg <= 1'b0;
            end
        end
    end

    // Request capture; bytes past the eighth only count toward the length
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rx_cnt_reg <= IDX_ZERO;
            for (int i = 0; i < BUF_DEPTH; i++) begin
                req_reg[i] <= 8'h00;
            end
        end else if (ce) begin
            if (rx_take) begin
                if (rx_cnt_reg < REQ_LEN) begin
                    req_reg[rx_cnt_reg[2:0]] <= rx.data;
                end
                if (rx_cnt_reg != RX_CNT_MAX) begin
                    rx_cnt_reg <= rx_cnt_reg + CNT_STEP;
                end
            end else if (in_eval) begin
                rx_cnt_reg <= IDX_ZERO;
            end
        end
    end

    // Reply image, built once per received frame, accepted or not
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            resp_len_reg <= LEN_EXC;
            for (int i = 0; i < BUF_DEPTH; i++) begin
                resp_reg[i] <= 8'h00;
            end
        end else if (ce && in_eval) begin
            resp_reg[IDX_ADDR] <= own_addr;
            if (is_exc) begin
                resp_reg[IDX_FN] <= req_fn | EXC_MARK;
                resp_reg[IDX_SUB_HI] <= exc_code;
                resp_len_reg <= LEN_EXC;
            end else begin
                resp_reg[IDX_FN] <= req_fn;
                resp_reg[IDX_SUB_HI] <= req_reg[IDX_SUB_HI];
                resp_reg[IDX_SUB_LO] <= req_reg[IDX_SUB_LO];
                resp_reg[IDX_DAT_HI] <= reply_word[15:8];
                resp_reg[IDX_DAT_LO] <= reply_word[7:0];
                resp_len_reg <= LEN_NORMAL;
            end
        end
    end

    // Half duplex: bytes arriving while replying are ignored
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg <= ST_RX;
            busy_reg <= 1'b0;
        end else if (ce) begin
            unique case (state_reg)
                ST_RX: begin
                    if (rx.eof && !rx.valid && (rx_cnt_reg != IDX_ZERO)) begin
                        state_reg <= ST_EVAL;
                        busy_reg <= 1'b1;
                    end
                end
                ST_EVAL: begin
                    state_reg <= frame_ok ? ST_TX : ST_RX;
                    busy_reg <= frame_ok;
                end
                ST_TX: begin
                    // Busy drops on the edge that accepts the CRC high byte
                    if (tx_finish) begin
                        state_reg <= ST_RX;
                        busy_reg <= 1'b0;
                    end
                end
                default: begin
                    state_reg <= ST_RX;
                    busy_reg <= 1'b0;
                end
            endcase
        end
    end

    // Byte slot reloads on the same edge that hands the old byte over
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            idx_reg <= IDX_ZERO;
            tx_reg <= '0;
        end else if (ce) begin
            if (in_eval) begin
                idx_reg <= IDX_ZERO;
            end else if (tx_load) begin
                tx_reg.valid <= 1'b1;
                tx_reg.data <= tx_byte;
                tx_reg.last <= (idx_reg == idx_crc_hi);
                idx_reg <= idx_reg + CNT_STEP;
            end else if (tx_finish) begin
                tx_reg <= '0;
            end
        end
    end

    assign tx = tx_reg;
    assign overrun_flag = ovr_flag_reg;
    assign overrun_count = ovr_cnt_reg;
    assign busy = busy_reg;
endmodule // mdc_responder

`default_nettype wire

// ### sim/mdc_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module mdc_master_model
    import mdc_pkg::*;
(
    input wire logic clock,
    input wire mdc_tx_t tx,
    output mdc_rx_t rx,
    output logic tx_ready
);
    logic [7:0] got[$];
    logic slow = 1'b0;
    initial rx = '0;
    initial tx_ready = 1'b0;
    // Reflected CRC over address through data
    function automatic logic [15:0] crc16(input logic [7:0] b[$]);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (b[i]) begin
            c = c ^ {8'h00, b[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
        end
        return c;
    endfunction
    // Frame order, CRC low then high, eof after one idle cycle
    task automatic send(input logic [7:0] b[$], input logic bad);
        logic [15:0] c;
        c = crc16(b) ^ {15'h0000, bad};
        b.push_back(c[7:0]);
        b.push_back(c[15:8]);
        foreach (b[i]) begin
            @(negedge clock);
            rx <= {2'b10, b[i]};
        end
        @(negedge clock);
        // Released line must not echo the last byte
        rx <= {2'b00, ~rx.data};
        @(negedge clock);
        rx <= {2'b01, rx.data};
        @(negedge clock);
        rx.eof <= 1'b0;
    endtask
    always @(negedge clock) tx_ready <= slow ? ~tx_ready : 1'b1;
    always @(posedge clock) if (tx.valid && tx_ready) got.push_back(tx.data);
endmodule // mdc_master_model
`default_nettype wire

// ### sim/mdc_responder_chk.sv
`timescale 1ns/1ps
`default_nettype none
module mdc_responder_chk
    import mdc_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic [7:0] own_addr,
    input wire mdc_rx_t rx,
    input wire logic tx_ready,
    input wire logic overrun_evt,
    input wire logic restart,
    input wire logic diag_clear,
    input wire mdc_tx_t tx,
    input wire logic overrun_flag,
    input wire logic [15:0] overrun_count,
    input wire logic busy
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Busy excluded: the overrun clear command lands while busy
    wire logic quiet = ce && !restart && !diag_clear && !busy;
    // First byte is loaded on the edge that ends the first reply cycle, one edge after the evaluation cycle ends
    sequence s_eof_start;
        ce && !busy && rx.eof && !rx.valid ##1 busy ##1 busy ##1 tx.valid;
    endsequence
    sequence s_take_last; ce && tx.valid && tx.last && tx_ready; endsequence
    property p_inc; quiet && overrun_evt && overrun_count != 16'hFFFF
        |=> overrun_count == $past(overrun_count) + 16'h0001; endproperty
    property p_hold; quiet && !overrun_evt |=> $stable(overrun_count); endproperty
    property p_sat; quiet && overrun_count == 16'hFFFF |=> overrun_count == 16'hFFFF; endproperty
    property p_clr; ce && (restart || diag_clear) && !overrun_evt |=> overrun_count == 16'h0000;
    endproperty
    property p_rflag; ce && restart && !overrun_evt |=> !overrun_flag; endproperty
    property p_flag; ce && overrun_evt |=> overrun_flag; endproperty
    property p_stall; ce && tx.valid && !tx_ready |=> tx.valid && $stable(tx.data); endproperty
    property p_end; s_take_last |=> !tx.valid && !busy; endproperty
    property p_first; s_eof_start |-> tx.data == own_addr; endproperty
    a_inc: assert property (p_inc) else $error("count did not step by one");
    a_hold: assert property (p_hold) else $error("count moved without cause");
    a_sat: assert property (p_sat) else $error("count left its ceiling");
    a_clr: assert property (p_clr) else $error("count not cleared");
    a_rflag: assert property (p_rflag) else $error("flag not cleared on restart");
    a_flag: assert property (p_flag) else $error("flag not set by overrun");
    a_stall: assert property (p_stall) else $error("reply byte changed while stalled");
    a_end: assert property (p_end) else $error("reply did not end after last byte");
    a_first: assert property (p_first) else $error("reply does not open with address");
endmodule // mdc_responder_chk
bind mdc_responder mdc_responder_chk i_chk (.clock(clock), .rst(rst), .ce(ce),
    .own_addr(own_addr), .rx(rx), .tx_ready(tx_ready), .overrun_evt(overrun_evt),
    .restart(restart), .diag_clear(diag_clear), .tx(tx), .overrun_flag(overrun_flag),
    .overrun_count(overrun_count), .busy(busy));
`default_nettype wire

// ### sim/test_modbus_diag_counter_responder.sv
`timescale 1ns/1ps
`default_nettype none
module test_modbus_diag_counter_responder
    import mdc_pkg::*;
;
    typedef struct {
        logic [7:0] fn;
        logic [15:0] sub;
        logic [15:0] dat;
        logic [7:0] code;
        logic [15:0] word;
    } mdc_row_t;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic overrun_evt = 1'b0;
    logic restart = 1'b0;
    logic diag_clear = 1'b0;
    logic ce = 1'b1;
    logic busy;
    logic tx_ready;
    mdc_rx_t rx;
    mdc_tx_t tx;
    logic overrun_flag;
    logic [15:0] overrun_count;
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;
    mdc_row_t rows[7] = '{
        '{8'h08, 16'h0011, 16'h0000, 8'h00, 16'h0000},
        '{8'h08, 16'h0012, 16'h0000, 8'h00, 16'h0003},
        '{8'h08, 16'h0014, 16'h0000, 8'h00, 16'h0000},
        '{8'h08, 16'h0012, 16'h0000, 8'h00, 16'h0000},
        '{8'h03, 16'h0011, 16'h0000, 8'h01, 16'h0000},
        '{8'h08, 16'h0013, 16'h0000, 8'h02, 16'h0000},
        '{8'h08, 16'h0011, 16'h0001, 8'h03, 16'h0000}
    };
    mdc_responder i_mdc_responder (.clock(clock), .rst(rst), .ce(ce), .own_addr(8'h01),
        .rx(rx), .tx_ready(tx_ready), .overrun_evt(overrun_evt), .restart(restart),
        .diag_clear(diag_clear), .tx(tx), .overrun_flag(overrun_flag),
        .overrun_count(overrun_count), .busy(busy));
    mdc_master_model i_mdc_master_model (.clock(clock), .tx(tx), .rx(rx), .tx_ready(tx_ready));
    initial forever #25 clock = ~clock;
    task automatic wrap_up();
        if (failures == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 90000) begin
            failures++;
            wrap_up();
        end
    end
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic xfer(input mdc_row_t r, input int len);
        logic [7:0] q[$];
        logic [7:0] e[$];
        logic [15:0] c;
        int n;
        q = {8'h01, r.fn, r.sub[15:8], r.sub[7:0], r.dat[15:8], r.dat[7:0]};
        q = q[0:len-1];
        if (r.code === 8'h00) e = {8'h01, r.fn, r.sub[15:8], r.sub[7:0], r.word[15:8], r.word[7:0]};
        else e = {8'h01, r.fn | 8'h80, r.code};
        c = i_mdc_master_model.crc16(e);
        e.push_back(c[7:0]);
        e.push_back(c[15:8]);
        i_mdc_master_model.got.delete();
        i_mdc_master_model.send(q, 1'b0);
        n = 0;
        while (i_mdc_master_model.got.size() < e.size() && n < 300) begin
            @(negedge clock);
            n++;
        end
        repeat (3) @(negedge clock);
        check("reply length", 16'(i_mdc_master_model.got.size()), 16'(e.size()));
        foreach (e[i]) check("reply byte", {8'h00, i_mdc_master_model.got[i]}, {8'h00, e[i]});
        check("busy", {15'h0000, busy}, 16'h0000);
    endtask
    task automatic pulse(ref logic s, input int k);
        @(negedge clock);
        s = 1'b1;
        repeat (k) @(negedge clock);
        s = 1'b0;
    endtask
    initial begin
        repeat (5) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        check("count", overrun_count, 16'h0000);
        check("flag", {15'h0000, overrun_flag}, 16'h0000);
        check("busy", {15'h0000, busy}, 16'h0000);
        check("tx valid", {15'h0000, tx.valid}, 16'h0000);
        ce = 1'b0;
        pulse(overrun_evt, 2);
        check("frozen count", overrun_count, 16'h0000);
        check("frozen flag", {15'h0000, overrun_flag}, 16'h0000);
        ce = 1'b1;
        pulse(overrun_evt, 3);
        check("count", overrun_count, 16'h0003);
        check("flag", {15'h0000, overrun_flag}, 16'h0001);
        foreach (rows[i]) begin
            i_mdc_master_model.slow = (i == 1);
            xfer(rows[i], 6);
            if (i == 2) check("flag", {15'h0000, overrun_flag}, 16'h0000);
        end
        xfer('{8'h08, 16'h0011, 16'h0000, 8'h04, 16'h0000}, 5);
        i_mdc_master_model.got.delete();
        i_mdc_master_model.send('{8'h02, 8'h08, 8'h00, 8'h11, 8'h00, 8'h00}, 1'b0);
        repeat (3) @(negedge clock);
        i_mdc_master_model.send('{8'h01, 8'h08, 8'h00, 8'h11, 8'h00, 8'h00}, 1'b1);
        repeat (20) @(negedge clock);
        check("dropped", 16'(i_mdc_master_model.got.size()), 16'h0000);
        pulse(overrun_evt, 65536);
        check("count", overrun_count, 16'hFFFF);
        xfer('{8'h08, 16'h0012, 16'h0000, 8'h00, 16'hFFFF}, 6);
        pulse(diag_clear, 1);
        check("count", overrun_count, 16'h0000);
        pulse(overrun_evt, 2);
        pulse(restart, 1);
        check("count", overrun_count, 16'h0000);
        check("flag", {15'h0000, overrun_flag}, 16'h0000);
        pulse(overrun_evt, 1);
        pulse(rst, 1);
        check("count", overrun_count, 16'h0000);
        check("flag", {15'h0000, overrun_flag}, 16'h0000);
        wrap_up();
    end
endmodule // test_modbus_diag_counter_responder
`default_nettype wire
